// ---- rtl/capctl_pkg.sv ----
package capctl_pkg;
    // ********************************
    // Timing
    // ********************************
    localparam int CLK_NS = 10;
    localparam int SEC_NS = 1_000_000_000;
    localparam int TICK_CYC = SEC_NS / CLK_NS;
    localparam int LONG_PRESS_S = 5;
    localparam int RELAY_DIV = 5;
    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] A_SWITCH = 8'h00;
    localparam logic [7:0] A_POT = 8'h04;
    localparam logic [7:0] A_MEAS = 8'h08;
    localparam logic [7:0] A_ANGLE = 8'h0C;
    localparam logic [7:0] A_STATUS = 8'h10;
    localparam logic [7:0] A_DISP = 8'h14;
    // ********************************
    // Fields and reset values
    // ********************************
    localparam int F_SEQ = 0;
    localparam int F_LOCK = 3;
    localparam int F_LIM = 6;
    localparam logic [9:0] SWITCH_RST = 10'h0D8;
    localparam logic [31:0] POT_RST = 32'h0000_6432;
    localparam logic [8:0] ANG_OK = 9'h05A;
    localparam logic [8:0] BAND_LO = 9'h000;
    localparam logic [8:0] BAND_HI = 9'h0B4;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // ********************************
    // Tables
    // ********************************
    localparam logic [9:0] LOCK_S [8] = '{10'h00A, 10'h014,
        10'h01E, 10'h03C, 10'h0B4, 10'h12C, 10'h1E0, 10'h258};
    // First four stage weights per sequence, later stages repeat the 4th
    localparam logic [15:0] WGT [8] = '{16'h1111, 16'h2211,
        16'h2221, 16'h3321, 16'h4321, 16'h4421, 16'h6321, 16'h8421};
    localparam logic [3:0] SEQ_MAXLIM [8] = '{4'hC, 4'hC, 4'hC,
        4'hC, 4'h9, 4'h9, 4'h7, 4'h6};
    localparam logic [3:0] NSTAGE = 4'hC;
    localparam logic [7:0] SYM_NONE = 8'h20;
    localparam logic [7:0] SYM_SEQ = 8'h53;
    localparam logic [7:0] SYM_TIME = 8'h74;
    localparam logic [7:0] SYM_LIM = 8'h4C;
    localparam logic [7:0] SYM_RATIO = 8'h63;
    localparam logic [7:0] SYM_COS = 8'h43;
    typedef enum logic [2:0] {PG_NORM, PG_SEQ, PG_TIME, PG_LIM,
        PG_RATIO, PG_COS} page_e;
endpackage

// ---- rtl/capctl.sv ----
`timescale 1ns/1ns
// Summary of operation
// - Switches 4-6 select lockout 10..600 s, switch 4 least significant.
// - Expanded display page after sequence shows lockout with 't'.
// - Stage limit ranges from 1 to 12.
// - Switches 7-10 form binary limit, switch 7 least significant.
// - No stage above the limit is ever energised.
// - Maximum step count is the weight sum of stages up to limit.
// - Limit clamped to 9, 9, 7, 6 for sequences 4, 5, 6, 7.
// - Expanded display page shows stage limit with 'L'.
// - Expanded display page shows step ratio with small 'c'.
// - Expanded display page shows target setting with large 'C'.
// - Add a step when lagging vars exceed three quarters of a step.
// - Remove a step when leading vars exceed three quarters of a step.
// - Current-to-voltage angle accepted within 90 degrees of 90.
// - Angle in band: automatic mode, no connection error.
// - Reversed transformer shows 270 degrees with connection error.
// - Wrong phase pair shows 150 degrees, inside the band: no connection error.
// - CA pair shows 210 degrees with connection error.
// - Displayed error angle follows the measured system angle.
// - AB pair: no error, shows 60 degrees leading.
// - AC pair: no error, shows 60 degrees lagging.
// - Lower button held over 5 s enters or leaves expanded display.
// - Relay acts after lockout/5 of demand, once lockout elapsed.
module capctl
    import capctl_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic btn_lower,
    output logic [11:0] stage_out,
    output logic conn_error,
    output logic auto_mode
);
    // ********************************
    // Registers
    // ********************************
    logic [9:0] sw_r;
    logic [31:0] pot_r, meas_r;
    logic [8:0] ang_r;
    logic [7:0] awa_r;
    logic aw_r, w_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    logic [31:0] tick_cnt_r;
    logic tick_r;
    logic [9:0] lock_cnt_r, relay_cnt_r;
    logic [5:0] step_r;
    logic [2:0] press_r;
    logic btn_q_r, expanded_r, refused_r;
    page_e page_r;
    logic [7:0] sym_r;
    logic [15:0] val_r;

    // ********************************
    // Setup decode
    // ********************************
    logic [2:0] seq;
    logic [9:0] lock_s, relay_s;
    logic [3:0] lim_raw, lim;
    logic [5:0] max_steps;
    logic [11:0] on_map;
    assign seq = sw_r[F_SEQ +: 3];
    assign lock_s = LOCK_S[sw_r[F_LOCK +: 3]];
    assign relay_s = lock_s / 10'(RELAY_DIV);
    assign lim_raw = sw_r[F_LIM +: 4];

    always_comb begin
        lim = lim_raw;
        if (lim == 4'h0) begin
            lim = 4'h1;
        end
        if (lim > SEQ_MAXLIM[seq]) begin
            lim = SEQ_MAXLIM[seq];
        end
    end

    function automatic logic [3:0] wgt(input logic [2:0] s,
                                       input int i);
        logic [15:0] w;
        w = WGT[s];
        wgt = (i < 4) ? w[4*i +: 4] : w[15:12];
    endfunction

    // Greedy fill from the top stage keeps the map within limit
    always_comb begin
        logic [5:0] rem;
        rem = step_r;
        max_steps = 6'h00;
        on_map = 12'h000;
        for (int i = 11; i >= 0; i--) begin
            if (4'(i) < lim) begin
                max_steps = max_steps + 6'(wgt(seq, i));
                if (6'(wgt(seq, i)) <= rem) begin
                    on_map[i] = 1'b1;
                    rem = rem - 6'(wgt(seq, i));
                end
            end
        end
    end

    // ********************************
    // Demand, timers and stepping
    // ********************************
    logic signed [15:0] q;
    logic [17:0] q4, s3;
    logic dem_up, dem_dn, lock_done, act;
    assign q = meas_r[15:0];
    assign q4 = q[15] ? 18'(-q) << 2 : 18'(q) << 2;
    assign s3 = 18'(meas_r[31:16]) * 18'h3;
    assign dem_up = !q[15] && (q4 > s3);
    assign dem_dn = q[15] && (q4 > s3);
    assign lock_done = lock_cnt_r >= lock_s;
    assign act = tick_r && auto_mode && lock_done
        && (relay_cnt_r + 10'h1 >= relay_s);

    always_ff @(posedge aclk) begin
        if (!aresetn || tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
        tick_r <= aresetn && tick_cnt_r == 32'(TICK_CYCLES - 1);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            relay_cnt_r <= 10'h0;
        end else if (!(dem_up || dem_dn) || act) begin
            relay_cnt_r <= 10'h0;
        end else if (tick_r) begin
            relay_cnt_r <= relay_cnt_r + 10'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_r <= 6'h00;
            lock_cnt_r <= 10'h0;
        end else if (step_r > max_steps) begin
            step_r <= max_steps;
            lock_cnt_r <= 10'h0;
        end else if (act && dem_dn && step_r != 6'h00) begin
            step_r <= step_r - 6'h01;
            lock_cnt_r <= 10'h0;
        end else if (act && dem_up && step_r < max_steps) begin
            step_r <= step_r + 6'h01;
        end else if (tick_r && !lock_done) begin
            lock_cnt_r <= lock_cnt_r + 10'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_out <= 12'h000;
            conn_error <= 1'b0;
            auto_mode <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            stage_out <= on_map;
            conn_error <= !(ang_r > BAND_LO && ang_r < BAND_HI);
            auto_mode <= ang_r > BAND_LO && ang_r < BAND_HI;
            refused_r <= lim_raw > SEQ_MAXLIM[seq];
        end
    end

    // ********************************
    // Button and expanded display
    // ********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            btn_q_r <= 1'b0;
            press_r <= 3'h0;
            expanded_r <= 1'b0;
            page_r <= PG_NORM;
        end else begin
            btn_q_r <= btn_lower;
            if (!btn_lower) begin
                press_r <= 3'h0;
            end else if (tick_r && press_r <= 3'(LONG_PRESS_S)) begin
                press_r <= press_r + 3'h1;
            end
            if (tick_r && btn_lower && press_r == 3'(LONG_PRESS_S)) begin
                expanded_r <= !expanded_r;
                page_r <= PG_NORM;
            end else if (expanded_r && btn_lower && !btn_q_r) begin
                unique case (page_r)
                    PG_NORM: page_r <= PG_SEQ;
                    PG_SEQ: page_r <= PG_TIME;
                    PG_TIME: page_r <= PG_LIM;
                    PG_LIM: page_r <= PG_RATIO;
                    PG_RATIO: page_r <= PG_COS;
                    PG_COS: page_r <= PG_NORM;
                    default: page_r <= PG_NORM;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sym_r <= SYM_NONE;
            val_r <= 16'h0000;
        end else begin
            unique case (page_r)
                PG_SEQ: begin
                    sym_r <= SYM_SEQ;
                    val_r <= 16'(seq);
                end
                PG_TIME: begin
                    sym_r <= SYM_TIME;
                    val_r <= 16'(lock_s);
                end
                PG_LIM: begin
                    sym_r <= SYM_LIM;
                    val_r <= 16'(lim);
                end
                PG_RATIO: begin
                    sym_r <= SYM_RATIO;
                    val_r <= 16'(pot_r[7:0]);
                end
                PG_COS: begin
                    sym_r <= SYM_COS;
                    val_r <= 16'(pot_r[15:8]);
                end
                default: begin
                    // Measured angle shown as is: 270, 150, 210, 230...
                    sym_r <= SYM_NONE;
                    val_r <= 16'(ang_r);
                end
            endcase
        end
    end

    // ********************************
    // AXI4-Lite slave
    // ********************************
    logic wr_go, mapped_w, mapped_r;
    assign wr_go = aw_r && w_r && !bvalid;
    assign mapped_w = awa_r[7:2] <= A_ANGLE[7:2];
    assign mapped_r = araddr[7:2] <= A_DISP[7:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            awa_r <= 8'h00;
            wd_r <= 32'h0;
            ws_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OK;
        end else begin
            if (awvalid && awready) begin
                aw_r <= 1'b1;
                awa_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_r <= 1'b1;
                wd_r <= wdata;
                ws_r <= wstrb;
            end
            if (wr_go) begin
                aw_r <= 1'b0;
                w_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= mapped_w ? RESP_OK : RESP_ERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    assign awready = !aw_r;
    assign wready = !w_r;

    function automatic logic [31:0] merge(input logic [31:0] o,
        input logic [31:0] d, input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            o[8*b +: 8] = s[b] ? d[8*b +: 8] : o[8*b +: 8];
        end
        merge = o;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_r <= SWITCH_RST;
            pot_r <= POT_RST;
            meas_r <= 32'h0;
            ang_r <= ANG_OK;
        end else if (wr_go) begin
            unique case (awa_r[7:2])
                A_SWITCH[7:2]: sw_r <= merge(32'(sw_r), wd_r, ws_r)[9:0];
                A_POT[7:2]: pot_r <= merge(pot_r, wd_r, ws_r);
                A_MEAS[7:2]: meas_r <= merge(meas_r, wd_r, ws_r);
                A_ANGLE[7:2]: ang_r <= merge(32'(ang_r), wd_r, ws_r)[8:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OK;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= mapped_r ? RESP_OK : RESP_ERR;
            unique case (araddr[7:2])
                A_SWITCH[7:2]: rdata <= 32'(sw_r);
                A_POT[7:2]: rdata <= pot_r;
                A_MEAS[7:2]: rdata <= meas_r;
                A_ANGLE[7:2]: rdata <= 32'(ang_r);
                A_STATUS[7:2]: rdata <= {10'h0, step_r, refused_r,
                    expanded_r, auto_mode, conn_error, stage_out};
                A_DISP[7:2]: rdata <= {val_r, 8'h00, sym_r};
                default: rdata <= 32'h0;
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
    assign arready = !rvalid;

    // ********************************
    // Assertions
    // ********************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_lock60;
        sw_r[F_LOCK +: 3] == 3'h3 |-> lock_s == 10'd60;
    endproperty
    a_lock60: assert property (p_lock60)
        else $error("lockout decode wrong");
    property p_limrange;
        lim >= 4'd1 && lim <= 4'd12;
    endproperty
    a_limrange: assert property (p_limrange)
        else $error("limit out of range");
    property p_lim12;
        lim_raw == 4'hC && seq == 3'h0 |-> lim == 4'd12;
    endproperty
    a_lim12: assert property (p_lim12)
        else $error("limit decode wrong");
    property p_above;
        ##1 (stage_out >> $past(lim)) == 12'h000;
    endproperty
    a_above: assert property (p_above)
        else $error("stage above limit on");
    property p_max33;
        seq == 3'h3 && lim == 4'd12 |-> max_steps == 6'd33;
    endproperty
    a_max33: assert property (p_max33)
        else $error("step count wrong");
    property p_seq7;
        seq == 3'h7 |-> lim <= 4'd6;
    endproperty
    a_seq7: assert property (p_seq7)
        else $error("limit not refused");
    property p_up;
        step_r == $past(step_r) + 6'h1 |-> $past(dem_up)
            && $past(lock_done) && $past(relay_cnt_r) + 10'h1 >= relay_s;
    endproperty
    a_up: assert property (p_up)
        else $error("step added without cause");
    property p_dn;
        $past(act && dem_dn && step_r != 6'h0) |-> lock_cnt_r == 10'h0
            ##1 !(step_r > $past(step_r));
    endproperty
    a_dn: assert property (p_dn)
        else $error("lockout not restarted");
    property p_conn;
        ang_r == 9'd270 ##1 ang_r == 9'd270 |-> conn_error && !auto_mode;
    endproperty
    a_conn: assert property (p_conn)
        else $error("reversed transformer not flagged");
    property p_long;
        $rose(expanded_r) |-> $past(press_r) == 3'(LONG_PRESS_S);
    endproperty
    a_long: assert property (p_long)
        else $error("expanded entered early");
    property p_tpage;
        page_r == PG_TIME |=> sym_r == SYM_TIME;
    endproperty
    a_tpage: assert property (p_tpage)
        else $error("time page symbol wrong");
    c_add: cover property (step_r == 6'h0 ##1 step_r == 6'h1);
    c_rem: cover property (act && dem_dn && step_r != 6'h0);
    c_exp: cover property ($rose(expanded_r));
    c_err: cover property ($rose(conn_error));
endmodule

// ---- verification/contactor_bank.sv ----
`timescale 1ns/1ns
// ************************************************
// Contactor bank on the stage outputs
// ************************************************
module contactor_bank (
    input wire logic aclk,
    input wire logic [11:0] stage_out,
    input wire logic [3:0] fitted,
    output logic [11:0] closed,
    output logic stray
);
    initial closed = 12'h000;
    // Contactors pull in one cycle after their coils
    always @(posedge aclk) begin
        closed <= stage_out;
    end
    // Only the fitted capacitors have a contactor behind them
    assign stray = (closed >> fitted) != 12'h000;
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
    import capctl_pkg::*;
    localparam int TK = 8;
    localparam int LIMIT = 60000;
    localparam int LOCK [8] = '{10, 20, 30, 60, 180, 300, 480, 600};
    localparam int LSEQ [5] = '{0, 0, 7, 4, 6};
    localparam int LCOD [5] = '{1, 12, 12, 10, 8};
    localparam int LEXP [5] = '{1, 12, 6, 9, 7};
    localparam int ANG [6] = '{60, 120, 150, 210, 230, 270};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic btn_lower = 1'b0;
    logic [3:0] fitted = 4'hC;
    logic awready, wready, bvalid, arready, rvalid;
    logic conn_error, auto_mode, stray;
    logic [1:0] bresp, rresp, brsp, rrsp;
    logic [31:0] rdata, rdat;
    logic [11:0] stage_out, closed;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    always #5 aclk = ~aclk;

    capctl #(.TICK_CYCLES(TK)) dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .btn_lower(btn_lower), .stage_out(stage_out),
        .conn_error(conn_error), .auto_mode(auto_mode));

    contactor_bank bank (.aclk(aclk), .stage_out(stage_out),
        .fitted(fitted), .closed(closed), .stray(stray));

    // ************************************************
    // Bus cycles and reporting
    // ************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        brsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rdat = rdata;
        rrsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic press(input int n);
        btn_lower <= 1'b1;
        repeat (n) @(posedge aclk);
        btn_lower <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic wait_steps(input int n);
        int k;
        k = 0;
        rd(A_STATUS);
        while (rdat[21:16] !== 6'(n) && k < 1000) begin
            rd(A_STATUS);
            k++;
        end
        check(32'(rdat[21:16]), 32'(n));
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            close_out();
        end
    end

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_reset;
        rd(A_SWITCH);
        check(rdat, 32'h0000_00D8);
        rd(A_POT);
        check(rdat, 32'h0000_6432);
        check(32'({auto_mode, conn_error}), 32'h2);
        rd(8'h18);
        check(32'({rrsp, rdat}), 32'({RESP_ERR, 32'h0}));
        wr(8'h18, 32'h1);
        check(32'(brsp), 32'(RESP_ERR));
    endtask

    task automatic t_angle;
        int e;
        for (int i = 0; i < 6; i++) begin
            wr(A_ANGLE, 32'(ANG[i]));
            repeat (3) @(posedge aclk);
            e = (ANG[i] >= 180) ? 1 : 0;
            check(32'(conn_error), 32'(e));
            check(32'(auto_mode), 32'(1 - e));
            rd(A_DISP);
            check(rdat, (ANG[i] << 16) | 32'(SYM_NONE));
        end
        wr(A_ANGLE, 32'd90);
        repeat (3) @(posedge aclk);
        check(32'({auto_mode, conn_error}), 32'h2);
    endtask

    task automatic t_display;
        press(4 * TK);
        rd(A_STATUS);
        check(32'(rdat[14]), 32'h0);
        press(8 * TK);
        rd(A_STATUS);
        check(32'(rdat[14]), 32'h1);
        press(2);
        rd(A_DISP);
        check(rdat, 32'(SYM_SEQ));
        press(2);
        for (int c = 0; c < 8; c++) begin
            wr(A_SWITCH, 32'((c << 3) | 192));
            rd(A_DISP);
            check(rdat, (LOCK[c] << 16) | 32'(SYM_TIME));
        end
        press(2);
        for (int i = 0; i < 5; i++) begin
            wr(A_SWITCH, 32'(LSEQ[i] | (LCOD[i] << 6)));
            rd(A_DISP);
            check(rdat, (LEXP[i] << 16) | 32'(SYM_LIM));
            rd(A_STATUS);
            check(32'(rdat[15]), 32'(LCOD[i] > LEXP[i]));
        end
        wr(A_POT, 32'h0000_4A21);
        press(2);
        rd(A_DISP);
        check(rdat, 32'h0021_0000 | 32'(SYM_RATIO));
        press(2);
        rd(A_DISP);
        check(rdat, 32'h004A_0000 | 32'(SYM_COS));
        press(2);
        rd(A_DISP);
        check(rdat, 32'h005A_0000 | 32'(SYM_NONE));
        press(8 * TK);
    endtask

    task automatic t_steps;
        wr(A_SWITCH, 32'h0000_0303);
        wr(A_MEAS, 32'h0064_004B);
        repeat (20 * TK) @(posedge aclk);
        wait_steps(0);
        wr(A_MEAS, 32'h0064_004C);
        wait_steps(33);
        check(32'(stage_out), 32'h0FFF);
        check(32'(stray), 32'h0);
        fitted <= 4'h6;
        wr(A_SWITCH, 32'h0000_0307);
        rd(A_STATUS);
        check(32'(rdat[15]), 32'h1);
        wait_steps(31);
        repeat (3) @(posedge aclk);
        check(32'(stage_out), 32'h003F);
        check(32'(stray), 32'h0);
        wr(A_MEAS, 32'h0064_FFB5);
        repeat (15 * TK) @(posedge aclk);
        wait_steps(31);
        wr(A_MEAS, 32'h0064_FFB4);
        wait_steps(30);
        repeat (8 * TK) @(posedge aclk);
        wait_steps(30);
        wait_steps(29);
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_angle();
        t_display();
        t_steps();
        close_out();
    end
endmodule
